/* msq_cfg.svh */
// Offsets, field positions, reset values and timing counts of the measurement sequencer.
// Assumes inclusion by bare name from the package and the checker.
`ifndef MSQ_CFG_SVH
`define MSQ_CFG_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define MSQ_CLK_PERIOD_NS 40
`define MSQ_CONV_UNIT_NS 1000
`define MSQ_CYC_PER_US (`MSQ_CONV_UNIT_NS / `MSQ_CLK_PERIOD_NS)
`define MSQ_CNT_W 24

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define MSQ_OFS_CYC 8'h00
`define MSQ_OFS_APP 8'h04
`define MSQ_OFS_STAT 8'h08
`define MSQ_OFS_RES0 8'h10
`define MSQ_NUM_CH 7

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MSQ_CYC_CNT_LSB 7
`define MSQ_CYC_CNT_MSB 9
`define MSQ_APP_T2E 0
`define MSQ_APP_T1E 1
`define MSQ_APP_REF 2
`define MSQ_APP_ORDER 3
`define MSQ_APP_RES_LSB 4
`define MSQ_APP_RES_MSB 7
`define MSQ_APP_RS_LSB 8
`define MSQ_APP_RS_MSB 9
`define MSQ_APP_XZC_LSB 10
`define MSQ_APP_XZC_MSB 15
`define MSQ_APP_GRP_LSB 16
`define MSQ_APP_GRP_MSB 17
`define MSQ_APP_XZE 18

// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define MSQ_RST_CNT_CODE 3'h0
`define MSQ_RST_RES 4'hc
`define MSQ_RES1_MIN 4'h9
`define MSQ_RES1_MAX 4'he
`define MSQ_RES2_MIN 4'hb
`define MSQ_RES2_MAX 4'hf

// ----------------------------------------------------------------------
// Range shift values in Q15 and zero shift step sizes in percent
// ----------------------------------------------------------------------
`define MSQ_RS_HALF 16'h4000
`define MSQ_RS_3Q 16'h6000
`define MSQ_RS_7E 16'h7000
`define MSQ_RS_15S 16'h7800
`define MSQ_Q15_ONE 18'h08000
`define MSQ_STEP_K30 5'h0f
`define MSQ_STEP_K18 5'h09
`define MSQ_STEP_K12 5'h06
`define MSQ_STEP_K02 5'h01
`define MSQ_SQRT2_MUL 32'h000000b5
`define MSQ_SQRT2_SHR 7

`endif

/* msq_ctl_if.sv */
// Control signals between the sequencer top, its step machine and its conversion timer.
// Assumes all three parties share one clock.
`timescale 1ns/1ps

interface msq_ctl_if;
  import msq_pkg::*;
  logic conv_start;
  logic conv_done;
  msq_chan_type mux_sel;
  logic [2:0] cnt_code;
  logic t1e;
  logic t2e;
  logic order;
  logic [3:0] res;

  modport seq (input conv_done, cnt_code, t1e, t2e, output conv_start, mux_sel);
  modport tim (input conv_start, order, res, output conv_done);
  modport top (input conv_start, conv_done, mux_sel, output cnt_code, t1e, t2e, order, res);
endinterface

/* msq_pkg.sv */
// Types shared by the measurement sequencer modules.
// Assumes msq_cfg.svh is on the include path.
`include "msq_cfg.svh"

package msq_pkg;

  // ----------------------------------------------------------------------
  // Multiplexer channels
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    MSQ_CH_BRIDGE = 3'b000,
    MSQ_CH_BR_AZ = 3'b001,
    MSQ_CH_T1 = 3'b010,
    MSQ_CH_T1_AZ = 3'b011,
    MSQ_CH_T2 = 3'b100,
    MSQ_CH_T2_AZ = 3'b101,
    MSQ_CH_CM = 3'b110
  } msq_chan_type;

  typedef enum logic [1:0] {
    MSQ_INIT = 2'b00,
    MSQ_START = 2'b01,
    MSQ_BRIDGE = 2'b10,
    MSQ_AUX = 2'b11
  } msq_seq_state_type;

  // ----------------------------------------------------------------------
  // Module state
  // ----------------------------------------------------------------------
  typedef struct packed {
    msq_seq_state_type state;
    logic [1:0] boot;
    logic [2:0] slot;
    logic [7:0] cnt;
    logic go;
    msq_chan_type mux;
  } msq_seq_type;

  typedef struct packed {
    logic run;
    logic done;
    logic [`MSQ_CNT_W-1:0] cnt;
  } msq_tim_type;

  typedef struct packed {
    logic [2:0] cnt_code;
    logic t2e;
    logic t1e;
    logic ref_sel;
    logic order;
    logic [3:0] res;
    logic [1:0] rs;
    logic [5:0] xzc;
    logic [1:0] grp;
    logic xze;
    logic [31:0] prdata;
    logic [`MSQ_NUM_CH-1:0][15:0] results;
    logic res_valid;
    msq_chan_type res_ch;
    logic [15:0] res_data;
  } msq_top_type;

endpackage

/* msq_sensor_model.sv */
// Sensor side model: bridge and temperature signals seen through the front end.
// Assumes a new signed fraction may be presented at every conversion start.
`timescale 1ns/1ps

module msq_sensor_model
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic conv_start,
  input wire logic [2:0] mux_sel,
  output logic signed [15:0] frac
);
  // ----------------------------------------------------------------------
  // Signal source
  // ----------------------------------------------------------------------
  logic [7:0] step_r;

  // Each conversion sees a different level, spread over the signed range.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      step_r <= 8'h00;
      frac <= 16'sh0000;
    end
    else if (conv_start)
    begin
      step_r <= step_r + 8'h01;
      frac <= {mux_sel, step_r, 5'h00} ^ 16'h8a50;
    end
  end
endmodule

/* msq_seq.sv */
// Step machine that walks the multiplexer through start routine and measurement cycle.
// Assumes one done pulse per start pulse from the conversion timer.
`timescale 1ns/1ps

module msq_seq
  import msq_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  msq_ctl_if.seq ctl
);

  msq_seq_type s_r;
  msq_seq_type s_nxt;
  logic [8:0] n_meas;
  logic [2:0] slot_inc;

  assign n_meas = 9'h001 << ctl.cnt_code; // R4
  assign slot_inc = s_r.slot + 3'h1;

  function automatic msq_chan_type aux_ch(input logic [2:0] slot);
    unique case (slot)
      3'h0: aux_ch = MSQ_CH_T1_AZ;
      3'h1: aux_ch = MSQ_CH_T1;
      3'h2: aux_ch = MSQ_CH_BR_AZ;
      3'h3: aux_ch = MSQ_CH_T2_AZ;
      3'h4: aux_ch = MSQ_CH_T2;
      default: aux_ch = MSQ_CH_CM;
    endcase
  endfunction

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.go = 1'b0;
    unique case (s_r.state)
      MSQ_INIT:
      begin
        s_nxt.state = MSQ_START; // R6
        s_nxt.boot = 2'h0;
        s_nxt.mux = MSQ_CH_BRIDGE;
        s_nxt.go = 1'b1;
      end
      MSQ_START:
      begin
        if (ctl.conv_done)
        begin
          s_nxt.go = 1'b1;
          if (s_r.boot == 2'h3 || (s_r.boot == 2'h1 && !ctl.t1e))
          begin
            s_nxt.state = MSQ_BRIDGE; // R6
            s_nxt.slot = 3'h0;
            s_nxt.cnt = 8'h00;
            s_nxt.mux = MSQ_CH_BRIDGE;
          end
          else
          begin
            s_nxt.boot = s_r.boot + 2'h1; // R6
            unique case (s_r.boot)
              2'h0: s_nxt.mux = MSQ_CH_BR_AZ;
              2'h1: s_nxt.mux = MSQ_CH_T1;
              default: s_nxt.mux = MSQ_CH_T1_AZ;
            endcase
          end
        end
      end
      MSQ_BRIDGE:
      begin
        if (ctl.conv_done)
        begin
          s_nxt.go = 1'b1;
          if ({1'b0, s_r.cnt} + 9'h001 >= n_meas)
          begin
            s_nxt.state = MSQ_AUX; // R7
            s_nxt.mux = aux_ch(s_r.slot);
          end
          else
          begin
            s_nxt.cnt = s_r.cnt + 8'h01; // R4
          end
        end
      end
      MSQ_AUX:
      begin
        if (ctl.conv_done)
        begin
          s_nxt.go = 1'b1;
          s_nxt.state = MSQ_BRIDGE;
          s_nxt.cnt = 8'h00;
          s_nxt.mux = MSQ_CH_BRIDGE;
          if (s_r.slot == 3'h5)
            s_nxt.slot = 3'h0; // R8
          else if (slot_inc == 3'h3 && !ctl.t2e)
            s_nxt.slot = 3'h5; // R5
          else
            s_nxt.slot = slot_inc; // R7
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign ctl.conv_start = s_r.go;
  assign ctl.mux_sel = s_r.mux;

endmodule

/* msq_timer.sv */
// Conversion timer: one done pulse a conversion time after each start pulse.
// Assumes the resolution it sees is already clamped to the legal range of the order.
`timescale 1ns/1ps

module msq_timer
  import msq_pkg::*;
#(
  parameter int CYC_PER_US = `MSQ_CYC_PER_US
)
(
  input wire logic clk,
  input wire logic arst_n,
  msq_ctl_if.tim ctl
);

  msq_tim_type t_r;
  msq_tim_type t_nxt;
  logic [4:0] half_exp;
  logic [31:0] base1;
  logic [31:0] base2;
  logic [31:0] period;

  // ----------------------------------------------------------------------
  // Conversion period in clock cycles
  // ----------------------------------------------------------------------
  assign half_exp = 5'({1'b0, ctl.res} + 5'h03);
  assign base1 = 32'(CYC_PER_US) << ctl.res; // R9
  assign base2 = (half_exp[0] ? (32'(CYC_PER_US) << half_exp[4:1]) * `MSQ_SQRT2_MUL
                  >> `MSQ_SQRT2_SHR : 32'(CYC_PER_US) << half_exp[4:1]); // R10
  assign period = ctl.order ? base2 : base1; // R15

  always_comb
  begin
    t_nxt = t_r;
    t_nxt.done = 1'b0;
    if (ctl.conv_start)
    begin
      t_nxt.run = 1'b1;
      t_nxt.cnt = `MSQ_CNT_W'(period - 32'h1);
    end
    else if (t_r.run)
    begin
      if (t_r.cnt == '0)
      begin
        t_nxt.run = 1'b0;
        t_nxt.done = 1'b1;
      end
      else
      begin
        t_nxt.cnt = t_r.cnt - `MSQ_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      t_r <= '0;
    else
      t_r <= t_nxt;
  end

  assign ctl.conv_done = t_r.done;

endmodule

/* msq_top.sv */
// Sensor measurement sequencer top: APB register file, conversion scaling and front-end setup.
// Assumes an APB master on REF_CLK and a converter that presents its fraction on ADC_FRAC.
`timescale 1ns/1ps

// Operation
// R1: Six-bit zero shift code drives analog offset.
// R2: Host programs zero shift within plus-minus 31.
// R3: Zero shift step size follows gain group.
// R4: Cycle word bits 9:7 set bridge count.
// R5: Second temperature bit skips its steps.
// R6: Start routine measures bridge, autozero, temperature one.
// R7: Fixed order of auxiliary steps with bridge groups.
// R8: After common mode the cycle repeats.
// R9: First order resolution 9 to 14 bits.
// R10: Second order resolution 11 to 15 bits.
// R11: Count scales fraction plus one minus shift.
// R12: Range shift is one of four values.
// R13: Reference bit selects bridge pin or supply.
// R14: Supply reference needs zero shift code zero.
// R15: Conversion time follows order and resolution.
// R16: Host sets resolution above output resolution.
// R17: Fine offset removal left to microcontroller.
module msq_top
  import msq_pkg::*;
#(
  parameter int CYC_PER_US = `MSQ_CYC_PER_US
)
(
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic signed [15:0] ADC_FRAC,
  output logic [2:0] MUX_SEL,
  output logic CONV_START,
  output logic CONV_ORDER,
  output logic [3:0] CONV_RES,
  output logic REF_SEL,
  output logic XZC_EN,
  output logic [5:0] XZC_CODE,
  output logic [4:0] XZC_STEP_PCT,
  output logic RESULT_VALID,
  output logic [2:0] RESULT_CH,
  output logic [15:0] RESULT_DATA
);

  msq_top_type r_r;
  msq_top_type r_nxt;
  msq_ctl_if ctl ();

  logic setup;
  logic access;
  logic [5:0] widx;
  logic mapped;
  logic [31:0] rd_mux;
  logic [3:0] res_eff;
  logic [15:0] rs_q15;
  logic signed [17:0] frac_sum;
  logic signed [33:0] scaled;
  logic signed [33:0] shifted;
  logic [15:0] count;

  // ----------------------------------------------------------------------
  // Step machine and conversion timer
  // ----------------------------------------------------------------------
  msq_seq u_seq
  (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .ctl(ctl)
  );

  msq_timer #(
    .CYC_PER_US(CYC_PER_US)
  ) u_timer
  (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .ctl(ctl)
  );

  assign ctl.cnt_code = r_r.cnt_code; // R4
  assign ctl.t1e = r_r.t1e;
  assign ctl.t2e = r_r.t2e; // R5
  assign ctl.order = r_r.order;
  assign ctl.res = res_eff;

  // ----------------------------------------------------------------------
  // Resolution limits per converter order
  // ----------------------------------------------------------------------
  always_comb
  begin
    res_eff = r_r.res;
    if (!r_r.order)
    begin
      if (r_r.res < `MSQ_RES1_MIN)
        res_eff = `MSQ_RES1_MIN; // R9
      else if (r_r.res > `MSQ_RES1_MAX)
        res_eff = `MSQ_RES1_MAX; // R9
    end
    else
    begin
      if (r_r.res < `MSQ_RES2_MIN)
        res_eff = `MSQ_RES2_MIN; // R10
    end
  end

  // ----------------------------------------------------------------------
  // Conversion count scaling
  // ----------------------------------------------------------------------
  always_comb
  begin
    unique case (r_r.rs)
      2'h0: rs_q15 = `MSQ_RS_HALF; // R12
      2'h1: rs_q15 = `MSQ_RS_3Q;
      2'h2: rs_q15 = `MSQ_RS_7E;
      default: rs_q15 = `MSQ_RS_15S;
    endcase
  end

  assign frac_sum = $signed({{2{ADC_FRAC[15]}}, ADC_FRAC}) + $signed(`MSQ_Q15_ONE)
                    - $signed({2'b00, rs_q15}); // R11
  assign scaled = $signed({{16{frac_sum[17]}}, frac_sum}) <<< res_eff; // R11
  assign shifted = scaled >>> 15;

  always_comb
  begin
    count = shifted[15:0];
    if (shifted[33])
      count = 16'h0000;
    else if (|shifted[32:16])
      count = 16'hffff;
  end

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign widx = PADDR[7:2];
  assign mapped = (PADDR == `MSQ_OFS_CYC) || (PADDR == `MSQ_OFS_APP)
                  || (PADDR == `MSQ_OFS_STAT)
                  || (PADDR >= `MSQ_OFS_RES0
                      && PADDR < `MSQ_OFS_RES0 + 8'(4 * `MSQ_NUM_CH)
                      && PADDR[1:0] == 2'b00);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (PADDR == `MSQ_OFS_CYC)
    begin
      rd_mux[`MSQ_CYC_CNT_MSB:`MSQ_CYC_CNT_LSB] = r_r.cnt_code;
    end
    else if (PADDR == `MSQ_OFS_APP)
    begin
      rd_mux[`MSQ_APP_T2E] = r_r.t2e;
      rd_mux[`MSQ_APP_T1E] = r_r.t1e;
      rd_mux[`MSQ_APP_REF] = r_r.ref_sel;
      rd_mux[`MSQ_APP_ORDER] = r_r.order;
      rd_mux[`MSQ_APP_RES_MSB:`MSQ_APP_RES_LSB] = r_r.res;
      rd_mux[`MSQ_APP_RS_MSB:`MSQ_APP_RS_LSB] = r_r.rs;
      rd_mux[`MSQ_APP_XZC_MSB:`MSQ_APP_XZC_LSB] = r_r.xzc;
      rd_mux[`MSQ_APP_GRP_MSB:`MSQ_APP_GRP_LSB] = r_r.grp;
      rd_mux[`MSQ_APP_XZE] = r_r.xze;
    end
    else if (PADDR == `MSQ_OFS_STAT)
    begin
      rd_mux[2:0] = ctl.mux_sel;
      rd_mux[8] = r_r.order;
      rd_mux[15:12] = res_eff;
    end
    else if (mapped)
    begin
      rd_mux[15:0] = r_r.results[3'(widx - 6'h04)]; // R17
    end
  end

  // ----------------------------------------------------------------------
  // Register file and result capture
  // ----------------------------------------------------------------------
  always_comb
  begin
    r_nxt = r_r;
    r_nxt.res_valid = 1'b0;
    if (setup)
    begin
      r_nxt.prdata = rd_mux;
    end
    if (access && PWRITE)
    begin
      if (PADDR == `MSQ_OFS_CYC)
      begin
        r_nxt.cnt_code = PWDATA[`MSQ_CYC_CNT_MSB:`MSQ_CYC_CNT_LSB]; // R4
      end
      else if (PADDR == `MSQ_OFS_APP)
      begin
        r_nxt.t2e = PWDATA[`MSQ_APP_T2E]; // R5
        r_nxt.t1e = PWDATA[`MSQ_APP_T1E];
        r_nxt.ref_sel = PWDATA[`MSQ_APP_REF]; // R13
        r_nxt.order = PWDATA[`MSQ_APP_ORDER];
        r_nxt.res = PWDATA[`MSQ_APP_RES_MSB:`MSQ_APP_RES_LSB];
        r_nxt.rs = PWDATA[`MSQ_APP_RS_MSB:`MSQ_APP_RS_LSB]; // R12
        r_nxt.xzc = PWDATA[`MSQ_APP_XZC_MSB:`MSQ_APP_XZC_LSB]; // R1
        r_nxt.grp = PWDATA[`MSQ_APP_GRP_MSB:`MSQ_APP_GRP_LSB];
        r_nxt.xze = PWDATA[`MSQ_APP_XZE];
      end
    end
    if (ctl.conv_done)
    begin
      r_nxt.results[ctl.mux_sel] = count; // R11
      r_nxt.res_valid = 1'b1;
      r_nxt.res_ch = ctl.mux_sel;
      r_nxt.res_data = count;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      r_r <= '0;
      r_r.cnt_code <= `MSQ_RST_CNT_CODE;
      r_r.t1e <= 1'b1;
      r_r.res <= `MSQ_RST_RES;
      r_r.xze <= 1'b1;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_comb
  begin
    unique case (r_r.grp)
      2'h0: XZC_STEP_PCT = `MSQ_STEP_K30; // R3
      2'h1: XZC_STEP_PCT = `MSQ_STEP_K18; // R3
      2'h2: XZC_STEP_PCT = `MSQ_STEP_K12; // R3
      default: XZC_STEP_PCT = `MSQ_STEP_K02; // R3
    endcase
  end

  assign PREADY = 1'b1;
  assign PSLVERR = access && !mapped;
  assign PRDATA = r_r.prdata;
  assign MUX_SEL = ctl.mux_sel;
  assign CONV_START = ctl.conv_start;
  assign CONV_ORDER = r_r.order;
  assign CONV_RES = res_eff;
  assign REF_SEL = r_r.ref_sel; // R13
  assign XZC_EN = r_r.xze;
  assign XZC_CODE = r_r.xzc; // R1
  assign RESULT_VALID = r_r.res_valid;
  assign RESULT_CH = r_r.res_ch;
  assign RESULT_DATA = r_r.res_data; // R17

endmodule

/* msq_top_sva.sv */
// Checker for the measurement sequencer top, watching only its ports.
// Assumes the register offsets of msq_cfg.svh and the hand-over timing.
`timescale 1ns/1ps
`include "msq_cfg.svh"

module msq_top_sva
#(
  parameter int CYC_PER_US = 25
)
(
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic signed [15:0] ADC_FRAC,
  input wire logic [2:0] MUX_SEL,
  input wire logic CONV_START,
  input wire logic CONV_ORDER,
  input wire logic [3:0] CONV_RES,
  input wire logic REF_SEL,
  input wire logic XZC_EN,
  input wire logic [5:0] XZC_CODE,
  input wire logic [4:0] XZC_STEP_PCT,
  input wire logic RESULT_VALID,
  input wire logic [2:0] RESULT_CH,
  input wire logic [15:0] RESULT_DATA
);
  // ----------------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------------
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  logic wr_app;
  logic wr_d_r;
  logic dirty_r;
  logic [31:0] cnt_r;
  logic [31:0] per_r;
  logic [2:0] ch_r;
  logic [3:0] res_r;
  logic [1:0] rs_r;

  function automatic logic [31:0] per_of(input logic o, input logic [3:0] r);
    logic [31:0] b;
    b = o ? (32'h1 << (({1'b0, r} + 5'h03) >> 1)) : (32'h1 << r);
    b = b * CYC_PER_US;
    if (o && !r[0])
      b = (b * 181) >> 7;
    return b;
  endfunction

  function automatic logic [3:0] res_of(input logic o, input logic [3:0] r);
    if (o)
      return (r < 4'hb) ? 4'hb : r;
    return (r < 4'h9) ? 4'h9 : ((r > 4'he) ? 4'he : r);
  endfunction

  function automatic logic [4:0] pct_of(input logic [1:0] g);
    return (g == 2'h0) ? 5'h0f : ((g == 2'h1) ? 5'h09 : ((g == 2'h2) ? 5'h06 : 5'h01));
  endfunction

  function automatic logic [15:0] cnt_of(input logic signed [15:0] f, input logic [1:0] rs,
    input logic [3:0] r);
    longint v;
    v = longint'(f) + (longint'(16384) >> rs);
    v = (v <<< r) >>> 15;
    return (v < 0) ? 16'h0000 : ((v > 65535) ? 16'hffff : v[15:0]);
  endfunction

  assign wr_app = PSEL && PENABLE && PWRITE && PADDR == `MSQ_OFS_APP;

  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      wr_d_r <= 1'b0;
      dirty_r <= 1'b0;
      cnt_r <= 32'h0;
      per_r <= 32'h0;
      ch_r <= 3'h0;
      res_r <= 4'h0;
      rs_r <= 2'h0;
    end
    else
    begin
      wr_d_r <= wr_app;
      dirty_r <= wr_app || wr_d_r || (dirty_r && !CONV_START);
      cnt_r <= CONV_START ? 32'h1 : cnt_r + 32'h1;
      if (CONV_START)
      begin
        per_r <= per_of(CONV_ORDER, CONV_RES);
        ch_r <= MUX_SEL;
        res_r <= CONV_RES;
      end
      if (wr_app)
        rs_r <= PWDATA[9:8];
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_xzc_code;
    wr_app |=> XZC_CODE == $past(PWDATA[15:10]) && XZC_EN == $past(PWDATA[18]);
  endproperty
  a_xzc_code: assert property (p_xzc_code)
    else $error("zero shift setting not loaded");
  property p_xzc_hold;
    !wr_app |=> $stable(XZC_CODE) && $stable(XZC_EN);
  endproperty
  a_xzc_hold: assert property (p_xzc_hold)
    else $error("zero shift setting changed without a write");
  property p_step;
    wr_app |=> XZC_STEP_PCT == pct_of($past(PWDATA[17:16]));
  endproperty
  a_step: assert property (p_step)
    else $error("zero shift step size wrong");
  property p_ref;
    wr_app |=> REF_SEL == $past(PWDATA[2]) && CONV_ORDER == $past(PWDATA[3]);
  endproperty
  a_ref: assert property (p_ref)
    else $error("reference or order select wrong");
  property p_res;
    wr_app |=> CONV_RES == res_of($past(PWDATA[3]), $past(PWDATA[7:4]));
  endproperty
  a_res: assert property (p_res)
    else $error("resolution not clamped to its range");
  property p_restart;
    RESULT_VALID |-> CONV_START;
  endproperty
  a_restart: assert property (p_restart)
    else $error("next conversion not started with the result");
  property p_chan;
    RESULT_VALID |-> RESULT_CH == ch_r;
  endproperty
  a_chan: assert property (p_chan)
    else $error("result channel differs from the started one");
  property p_time;
    RESULT_VALID && !dirty_r |-> cnt_r == per_r + 32'h2;
  endproperty
  a_time: assert property (p_time)
    else $error("conversion time wrong");
  property p_nohang;
    !dirty_r |-> cnt_r <= per_r + 32'h2;
  endproperty
  a_nohang: assert property (p_nohang)
    else $error("conversion overran its time");
  property p_count;
    RESULT_VALID && !dirty_r |-> RESULT_DATA == cnt_of($past(ADC_FRAC), rs_r, res_r);
  endproperty
  a_count: assert property (p_count)
    else $error("conversion count wrong");
endmodule

bind msq_top msq_top_sva #(.CYC_PER_US(CYC_PER_US)) u_sva (.REF_CLK, .ARST_N, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PWDATA, .ADC_FRAC, .MUX_SEL, .CONV_START, .CONV_ORDER, .CONV_RES, .REF_SEL,
  .XZC_EN, .XZC_CODE, .XZC_STEP_PCT, .RESULT_VALID, .RESULT_CH, .RESULT_DATA);

/* tb.sv */
// Testbench for the measurement sequencer: APB set-up, step order and counts.
// Assumes the sensor model on the converter side and a shortened microsecond.
`timescale 1ns/1ps

module tb;
  // ----------------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------------
  logic REF_CLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, CONV_START, CONV_ORDER;
  logic REF_SEL, XZC_EN, RESULT_VALID, chk_en, err;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic signed [15:0] ADC_FRAC, frac_d;
  logic [2:0] MUX_SEL, RESULT_CH;
  logic [3:0] CONV_RES, res_v;
  logic [5:0] XZC_CODE;
  logic [4:0] XZC_STEP_PCT;
  logic [15:0] RESULT_DATA, exp_cm;
  logic [1:0] rs_v;
  logic [2:0] seen[$];
  int bad_count, checks, cycles;

  msq_top #(.CYC_PER_US(1)) u_dut (.REF_CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .ADC_FRAC, .MUX_SEL, .CONV_START, .CONV_ORDER, .CONV_RES,
    .REF_SEL, .XZC_EN, .XZC_CODE, .XZC_STEP_PCT, .RESULT_VALID, .RESULT_CH, .RESULT_DATA);
  msq_sensor_model u_sensor (.clk(REF_CLK), .arst_n(ARST_N), .conv_start(CONV_START),
    .mux_sel(MUX_SEL), .frac(ADC_FRAC));

  initial
  begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end

  function automatic logic [15:0] cnt_of(input logic signed [15:0] f, input logic [1:0] rs,
    input logic [3:0] r);
    longint v;
    v = longint'(f) + (longint'(16384) >> rs);
    v = (v <<< r) >>> 15;
    return (v < 0) ? 16'h0000 : ((v > 65535) ? 16'hffff : v[15:0]);
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1)
      @(posedge REF_CLK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee, input string m);
    apb(1'b0, a, 32'h0);
    check(rd, e, m);
    check(err, ee, "error flag");
    check(PREADY, 1'b1, "ready");
  endtask

  task automatic do_reset();
    chk_en = 1'b0;
    ARST_N <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    seen.delete();
    @(posedge REF_CLK);
  endtask

  task automatic arm();
    int n;
    @(posedge REF_CLK);
    for (n = 0; n < 6000 && CONV_START !== 1'b1; n++)
      @(posedge REF_CLK);
    @(posedge REF_CLK);
    chk_en = 1'b1;
  endtask

  task automatic seq_chk(input logic [2:0] exp[$]);
    int n;
    for (n = 0; n < 20000 && seen.size() < exp.size(); n++)
      @(posedge REF_CLK);
    check(seen.size() >= exp.size(), 1'b1, "step count");
    foreach (exp[i])
      check(seen[i], exp[i], "channel order");
  endtask

  // Records started channels and checks every settled conversion count.
  always @(posedge REF_CLK)
  begin
    cycles <= cycles + 1;
    frac_d <= ADC_FRAC;
    if (ARST_N && CONV_START === 1'b1)
      seen.push_back(MUX_SEL);
    if (ARST_N && RESULT_VALID === 1'b1 && chk_en)
    begin
      check(RESULT_DATA, cnt_of(frac_d, rs_v, res_v), "conversion count");
      if (RESULT_CH === 3'h6)
        exp_cm = cnt_of(frac_d, rs_v, res_v);
    end
    if (cycles == 40000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  initial
  begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= '0;
    {bad_count, checks, cycles} = '0;
    {rs_v, res_v, exp_cm} = '0;
    do_reset();
    check({XZC_EN, XZC_STEP_PCT}, 6'h2f, "zero shift enable and step");
    check(CONV_RES, 4'hc, "resolution");
    rd_chk(8'h04, 32'h000400c2, 1'b0, "application word");
    rd_chk(8'h0c, 32'h0, 1'b1, "unmapped read");
    apb(1'b1, 8'h00, 32'h00000380);
    rd_chk(8'h00, 32'h00000380, 1'b0, "cycle word");
    $display("test defaults done");
    apb(1'b1, 8'h00, 32'h00000080);
    apb(1'b1, 8'h04, 32'h0005b1bb);
    rs_v = 2'h1;
    res_v = 4'hb;
    check(XZC_CODE, 6'h2c, "zero shift code");
    check(XZC_STEP_PCT, 5'h09, "step size");
    check({CONV_ORDER, CONV_RES}, 5'h1b, "order and resolution");
    arm();
    seq_chk('{0, 1, 2, 3, 0, 0, 3, 0, 0, 2, 0, 0, 1, 0, 0, 5, 0, 0, 4, 0, 0, 6, 0, 0, 3});
    apb(1'b1, 8'h28, 32'h0000ffff);
    rd_chk(8'h28, {16'h0, exp_cm}, 1'b0, "stored count");
    $display("test two temperatures done");
    do_reset();
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h04, 32'h00070354);
    rs_v = 2'h3;
    res_v = 4'h9;
    check(CONV_RES, 4'h9, "clamped resolution");
    check({REF_SEL, XZC_CODE, XZC_STEP_PCT}, 12'h801, "reference and step");
    apb(1'b0, 8'h08, 32'h0);
    check({rd[15:12], rd[8]}, 5'h12, "status");
    arm();
    seq_chk('{0, 1, 0, 3, 0, 2, 0, 1, 0, 6, 0, 3});
    $display("test single temperature done");
    report_and_stop();
  end
endmodule
